// file: hw/brs_defs.vh
// Constants for the bidirectional reset sequencer
`ifndef BRS_DEFS_VH
`define BRS_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BRS_CLK_PS 25000
`define BRS_CLOCK_UNIT_PS 12500
`define BRS_SEQ_TCL 1024
`define BRS_SAMPLE_TCL 8
`define BRS_SHORT_MIN_TCL 4
`define BRS_SEQ_CYC ((`BRS_SEQ_TCL * `BRS_CLOCK_UNIT_PS + `BRS_CLK_PS - 1) / `BRS_CLK_PS)
`define BRS_SAMPLE_CYC ((`BRS_SAMPLE_TCL * `BRS_CLOCK_UNIT_PS + `BRS_CLK_PS - 1) / `BRS_CLK_PS)
`define BRS_SHORT_MIN_CYC ((`BRS_SHORT_MIN_TCL * `BRS_CLOCK_UNIT_PS + `BRS_CLK_PS - 1) / `BRS_CLK_PS)

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define BRS_ADDR_SYSCFG 4'h0
`define BRS_ADDR_FLAGS 4'h4
`define BRS_ADDR_STATUS 4'h8
`define BRS_SYSCFG_PULLUP_BIT 0
`define BRS_SYSCFG_BIDIR_BIT 3
`define BRS_SYSCFG_RESET 32'h00000000

// Reset source flags: [4] power-on, [3] long hw, [2] short hw, [1] software, [0] watchdog
`define BRS_FLAGS_POWERON 5'h1e
`define BRS_FLAGS_ASYNC 5'h0e
`define BRS_FLAGS_LONG 5'h0e
`define BRS_FLAGS_SHORT 5'h06
`define BRS_FLAGS_SW 5'h02
`define BRS_FLAGS_WDT 5'h01

`define BRS_RESP_OKAY 2'h0
`define BRS_RESP_SLVERR 2'h2

`endif

// file: hw/brs_sequencer.v
// Reset sequencer with bidirectional reset pin and AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// - Flags follow the short/long classification actually made
// - Soft bidir reset: sample filtered input after 8
// - Degenerated reset overwrites software/watchdog flag
// - Degeneration normally classified short; long needs holding
// - Internal flash lengthens sequence; no degeneration
// - Bidir enabled: pull pin low during sequence
// - Reset output low until end-of-init
// - Pull-up config enables sense pull-up at end
// - Sense pull-down on while reset pin low
// - Sense low with reset low: asynchronous reset
// - Short pulses synchronous; long until sense low asynchronous
// - Sense low in soft reset releases pin
// - Bidir bit writable before init end, cleared
// - Filtered low at least 4 units for hardware
// - Sense low at soft reset: no pin pull
`include "brs_defs.vh"

module brs_sequencer #(
  parameter FLASH_EXT_CYC = 256
) (
  // Clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  // AXI4-Lite write address
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Reset sources, end of init and access select from the core
  input wire sw_reset_req,
  input wire wdt_reset_req,
  input wire end_of_init_instruction,
  input wire external_access_select,
  // Pins
  input wire filtered_reset_input,
  input wire reset_input_pin_in,
  output reg reset_input_pin_out,
  output reg reset_input_pin_oe,
  input wire powerdown_sense_pin,
  output reg sense_pulldown_en,
  output reg sense_pullup_en,
  output reg reset_output_pin,
  output reg core_reset_n
);

  // ----------------------------------------------------------------
  // States and kinds
  // ----------------------------------------------------------------
  localparam ST_RUN = 5'b00001;
  localparam ST_SEQ = 5'b00010;
  localparam ST_HOLD = 5'b00100;
  localparam ST_POST = 5'b01000;
  localparam ST_ASYNC = 5'b10000;

  // Counts are worked out as integers, then cut to the counter width on purpose
  localparam integer SEQ_CYC_I = `BRS_SEQ_CYC;
  localparam integer SAMPLE_CYC_I = `BRS_SAMPLE_CYC;
  localparam integer SHORT_MIN_CYC_I = `BRS_SHORT_MIN_CYC;
  localparam integer FLASH_CYC_I = FLASH_EXT_CYC;
  localparam [11:0] SEQ_CYC = SEQ_CYC_I[11:0];
  localparam [11:0] SAMPLE_CYC = SAMPLE_CYC_I[11:0];
  localparam [11:0] SHORT_MIN_CYC = SHORT_MIN_CYC_I[11:0];
  localparam [11:0] FLASH_CYC = FLASH_CYC_I[11:0];

  reg [4:0] state;
  reg [11:0] cnt;
  reg [11:0] low_cnt;
  reg soft_kind;
  reg bidir_drive;
  reg init_done;
  reg bidir_en;
  reg pullup_cfg;
  reg [4:0] flags;
  wire [11:0] seq_len;
  wire hw_seen;
  wire soft_req;
  reg aw_held;
  reg w_held;
  reg [3:0] wr_addr_q;
  reg [31:0] wr_data_q;
  reg wr_strb0_q;
  wire aw_take;
  wire w_take;
  wire wr_fire;
  wire [3:0] wr_addr;
  wire [31:0] wr_data;
  wire wr_strb0;

  assign seq_len = external_access_select ? (SEQ_CYC + FLASH_CYC) : SEQ_CYC;
  assign hw_seen = (low_cnt >= SHORT_MIN_CYC - 12'h001) && !filtered_reset_input;
  assign soft_req = sw_reset_req || wdt_reset_req;

  // ----------------------------------------------------------------
  // Filtered-input low-time counter
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt <= 12'h000;
    end else if (clk_en) begin
      if (filtered_reset_input) begin
        low_cnt <= 12'h000;
      end else if (low_cnt != 12'hfff) begin
        low_cnt <= low_cnt + 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_RUN;
      cnt <= 12'h000;
      soft_kind <= 1'b0;
      bidir_drive <= 1'b0;
      init_done <= 1'b0;
      bidir_en <= 1'b0;
      pullup_cfg <= 1'b0;
      flags <= `BRS_FLAGS_POWERON;
      reset_input_pin_out <= 1'b0;
      reset_input_pin_oe <= 1'b0;
      sense_pulldown_en <= 1'b0;
      sense_pullup_en <= 1'b0;
      reset_output_pin <= 1'b0;
      core_reset_n <= 1'b1;
    end else if (clk_en) begin
      sense_pulldown_en <= !reset_input_pin_in;
      reset_input_pin_out <= 1'b0;
      // Register writes to the config; data may have been taken before the address
      if (wr_fire && (wr_addr == `BRS_ADDR_SYSCFG) && wr_strb0) begin
        pullup_cfg <= wr_data[`BRS_SYSCFG_PULLUP_BIT];
        if (!init_done) begin
          bidir_en <= wr_data[`BRS_SYSCFG_BIDIR_BIT];
        end
      end
      if (end_of_init_instruction && (state == ST_RUN)) begin
        init_done <= 1'b1;
        reset_output_pin <= 1'b1;
      end
      case (state)
        ST_RUN: begin
          if (!filtered_reset_input && !powerdown_sense_pin) begin
            state <= ST_ASYNC;
            flags <= `BRS_FLAGS_ASYNC;
            cnt <= 12'h000;
            bidir_drive <= bidir_en;
            reset_input_pin_oe <= bidir_en;
            bidir_en <= 1'b0;
            init_done <= 1'b0;
            reset_output_pin <= 1'b0;
            core_reset_n <= 1'b0;
            sense_pullup_en <= 1'b0;
          end else if (hw_seen || soft_req) begin
            state <= ST_SEQ;
            soft_kind <= !hw_seen;
            if (!hw_seen) begin
              flags <= wdt_reset_req ? `BRS_FLAGS_WDT : `BRS_FLAGS_SW;
            end
            cnt <= 12'h000;
            bidir_drive <= bidir_en && (hw_seen || powerdown_sense_pin);
            reset_input_pin_oe <= bidir_en && (hw_seen || powerdown_sense_pin);
            bidir_en <= 1'b0;
            init_done <= 1'b0;
            reset_output_pin <= 1'b0;
            core_reset_n <= 1'b0;
            sense_pullup_en <= 1'b0;
          end
        end
        ST_SEQ: begin
          cnt <= cnt + 12'h001;
          if (soft_kind && !powerdown_sense_pin) begin
            bidir_drive <= 1'b0;
            reset_input_pin_oe <= 1'b0;
          end
          // Flash start-up runs with the pin already let go, so the filter settles before exit
          if (external_access_select && (cnt >= SEQ_CYC - 12'h001)) begin
            bidir_drive <= 1'b0;
            reset_input_pin_oe <= 1'b0;
          end
          if (!soft_kind && !filtered_reset_input && !powerdown_sense_pin) begin
            state <= ST_ASYNC;
            flags <= `BRS_FLAGS_ASYNC;
            cnt <= 12'h000;
          end else if (cnt >= seq_len - 12'h001) begin
            cnt <= 12'h000;
            bidir_drive <= 1'b0;
            reset_input_pin_oe <= 1'b0;
            if (soft_kind) begin
              // Without flash start-up the pin's filter still lags, so check it in ST_POST once it settles
              if (external_access_select) begin
                state <= ST_RUN;
                core_reset_n <= 1'b1;
                sense_pullup_en <= pullup_cfg;
              end else begin
                state <= ST_POST;
                core_reset_n <= 1'b1;
              end
            end else if (!filtered_reset_input) begin
              state <= ST_HOLD;
              flags <= `BRS_FLAGS_LONG;
            end else begin
              state <= ST_RUN;
              flags <= `BRS_FLAGS_SHORT;
              core_reset_n <= 1'b1;
              sense_pullup_en <= pullup_cfg;
            end
          end
        end
        ST_HOLD: begin
          // Long reset extends until the filtered input rises; a drained sense pin makes it asynchronous
          if (!filtered_reset_input && !powerdown_sense_pin) begin
            state <= ST_ASYNC;
            flags <= `BRS_FLAGS_ASYNC;
            cnt <= 12'h000;
          end else if (filtered_reset_input) begin
            state <= ST_RUN;
            core_reset_n <= 1'b1;
            sense_pullup_en <= pullup_cfg;
          end
        end
        ST_POST: begin
          cnt <= cnt + 12'h001;
          if (cnt >= SAMPLE_CYC - 12'h001) begin
            cnt <= 12'h000;
            if (!filtered_reset_input) begin
              state <= ST_SEQ;
              soft_kind <= 1'b0;
              flags <= `BRS_FLAGS_SHORT;
              core_reset_n <= 1'b0;
            end else begin
              state <= ST_RUN;
              sense_pullup_en <= pullup_cfg;
            end
          end
        end
        ST_ASYNC: begin
          cnt <= cnt + 12'h001;
          if (cnt >= seq_len - 12'h001 && filtered_reset_input) begin
            state <= ST_RUN;
            cnt <= 12'h000;
            bidir_drive <= 1'b0;
            reset_input_pin_oe <= 1'b0;
            core_reset_n <= 1'b1;
            sense_pullup_en <= pullup_cfg;
          end else if (cnt >= seq_len - 12'h001) begin
            cnt <= cnt;
            // Let the pin go, or a self-driven line would hold the block here for ever
            bidir_drive <= 1'b0;
            reset_input_pin_oe <= 1'b0;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
  assign wr_addr = aw_held ? wr_addr_q : s_axi_awaddr;
  assign wr_data = w_held ? wr_data_q : s_axi_wdata;
  assign wr_strb0 = w_held ? wr_strb0_q : s_axi_wstrb[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr_q <= 4'h0;
      wr_data_q <= 32'h00000000;
      wr_strb0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BRS_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid && !wr_fire;
      s_axi_wready <= !w_held && !w_take && !s_axi_bvalid && !wr_fire;
      if (aw_take && !wr_fire) begin
        aw_held <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
      end
      if (w_take && !wr_fire) begin
        w_held <= 1'b1;
        wr_data_q <= s_axi_wdata;
        wr_strb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_addr == `BRS_ADDR_SYSCFG || wr_addr == `BRS_ADDR_FLAGS ||
                        wr_addr == `BRS_ADDR_STATUS) ? `BRS_RESP_OKAY : `BRS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BRS_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `BRS_RESP_OKAY;
        case (s_axi_araddr)
          `BRS_ADDR_SYSCFG: s_axi_rdata <= {28'h0000000, bidir_en, 2'h0, pullup_cfg};
          `BRS_ADDR_FLAGS: s_axi_rdata <= {27'h0000000, flags};
          `BRS_ADDR_STATUS: s_axi_rdata <= {25'h0000000, init_done, ~core_reset_n, state};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BRS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // brs_sequencer

// file: verification/brs_reset_partner.sv
// External reset circuitry model: wired reset line, input filter lag, sense capacitor
`timescale 1ns/100ps

module brs_reset_partner #(
  parameter int FILT_CYC = 6,
  parameter int CAP_MAX = 2000
) (
  // Clock
  input wire logic aclk,
  // From the device
  input wire logic pin_oe,
  input wire logic pulldown_en,
  input wire logic pullup_en,
  // Bench controls
  input wire logic button_low,
  input wire logic sense_gnd,
  // To the device
  output logic pin_level,
  output logic filtered,
  output logic sense
);
  logic [15:0] filt_sr = 16'hffff;
  int cap = CAP_MAX;

  // Pulled-up line, low while anyone pulls; holding the button long injects a long reset
  assign pin_level = !(pin_oe || button_low);
  // Filter is a pure lag, so the line reads low a while after release
  assign filtered = filt_sr[FILT_CYC-1];
  // Capacitor drains slowly, so only a long low on the line reaches the threshold
  assign sense = !sense_gnd && (cap > CAP_MAX / 2);

  always @(posedge aclk) begin
    filt_sr <= {filt_sr[14:0], pin_level};
    if (pulldown_en) begin
      cap <= (cap > 0) ? cap - 1 : 0;
    end else if (cap < CAP_MAX) begin
      cap <= cap + (pullup_en ? 8 : 4);
    end
  end
endmodule // brs_reset_partner

// file: verification/brs_sequencer_props.sv
// Port-level checker for the reset sequencer
`timescale 1ns/100ps

module brs_sequencer_props #(
  parameter FLASH_EXT_CYC = 256
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core side
  input wire logic end_of_init_instruction,
  input wire logic external_access_select,
  input wire logic core_reset_n,
  // Pins
  input wire logic filtered_reset_input,
  input wire logic reset_input_pin_in,
  input wire logic reset_input_pin_oe,
  input wire logic powerdown_sense_pin,
  input wire logic sense_pulldown_en,
  input wire logic reset_output_pin
);
  localparam int SEQ_MIN = 511;
  int low_cnt;

  always @(posedge aclk) begin
    if (!aresetn || core_reset_n) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_oe_in_reset: assert property (reset_input_pin_oe |-> !core_reset_n)
    else $error("reset pin pulled outside a sequence");
  a_seq_len: assert property ($rose(core_reset_n) |-> low_cnt >= SEQ_MIN)
    else $error("reset sequence too short");
  a_flash_len: assert property ($rose(core_reset_n) && external_access_select |-> low_cnt >= SEQ_MIN + FLASH_EXT_CYC)
    else $error("flash sequence not lengthened");
  a_degen_start: assert property ((!external_access_select && $fell(reset_input_pin_oe) && core_reset_n)
    ##4 !filtered_reset_input |-> ##[0:4] !core_reset_n)
    else $error("no hardware reset after low sample");
  a_sense_release: assert property (reset_input_pin_oe && !powerdown_sense_pin |-> ##[1:2] !reset_input_pin_oe)
    else $error("pin not released on sense low");
  a_short_glitch: assert property ((core_reset_n && $fell(filtered_reset_input)) ##1 filtered_reset_input
    |-> ##1 core_reset_n [*4])
    else $error("glitch started a reset");
  a_pulldown_on: assert property ($fell(reset_input_pin_in) |-> ##[0:2] sense_pulldown_en)
    else $error("pull-down not on while pin low");
  a_reset_output_pin_end_of_init_instruction: assert property ($rose(reset_output_pin) |->
    $past(end_of_init_instruction) || $past(end_of_init_instruction, 2))
    else $error("reset output released without end of init");
  a_reset_output_pin_low: assert property (!core_reset_n && !$past(core_reset_n) |-> !reset_output_pin)
    else $error("reset output high during reset");
endmodule // brs_sequencer_props

bind brs_sequencer brs_sequencer_props #(.FLASH_EXT_CYC(FLASH_EXT_CYC)) u_brs_sequencer_props (
  .aclk, .aresetn, .end_of_init_instruction, .external_access_select, .core_reset_n, .filtered_reset_input,
  .reset_input_pin_in, .reset_input_pin_oe, .powerdown_sense_pin, .sense_pulldown_en, .reset_output_pin);

// file: verification/brs_sequencer_tb.sv
// Self-checking testbench for the reset sequencer
`timescale 1ns/100ps
`include "brs_defs.vh"

module brs_sequencer_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic sw_reset_req = 1'b0, wdt_reset_req = 1'b0, end_of_init_instruction = 1'b0, external_access_select = 1'b0;
  logic button_low = 1'b0, sense_gnd = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire filtered_reset_input, pin_level, reset_input_pin_oe, powerdown_sense_pin;
  wire sense_pulldown_en, sense_pullup_en, reset_output_pin, core_reset_n;
  wire pin_out;
  int error_cnt = 0;
  int comparisons = 0;

  always #12.5 aclk = ~aclk;

  // Flash stretch must outlast the partner's filter lag of six cycles
  brs_sequencer #(.FLASH_EXT_CYC(16)) u_brs_sequencer (.aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sw_reset_req, .wdt_reset_req, .end_of_init_instruction, .external_access_select,
    .filtered_reset_input, .reset_input_pin_in(pin_level), .reset_input_pin_out(pin_out), .reset_input_pin_oe,
    .powerdown_sense_pin, .sense_pulldown_en, .sense_pullup_en, .reset_output_pin, .core_reset_n);

  brs_reset_partner u_brs_reset_partner (.aclk, .pin_oe(reset_input_pin_oe), .pulldown_en(sense_pulldown_en),
    .pullup_en(sense_pullup_en), .button_low, .sense_gnd, .pin_level, .filtered(filtered_reset_input),
    .sense(powerdown_sense_pin));

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [31:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), er);
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [31:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    check(32'(s_axi_rresp), er);
    check(s_axi_rdata, ed);
  endtask

  // Sixteen quiet cycles: long enough to span the gap before a degenerated reset
  task automatic wait_idle;
    int run;
    int n;
    run = 0;
    for (n = 0; n < 6000 && run < 16; n++) begin
      @(posedge aclk);
      run = (core_reset_n === 1'b1) ? run + 1 : 0;
    end
    check(32'(run), 32'h10);
  endtask

  task automatic kick(input logic wdt);
    @(posedge aclk);
    if (wdt) wdt_reset_req <= 1'b1;
    else sw_reset_req <= 1'b1;
    @(posedge aclk);
    wdt_reset_req <= 1'b0;
    sw_reset_req <= 1'b0;
  endtask

  task automatic press(input int n);
    @(posedge aclk);
    button_low <= 1'b1;
    repeat (n) @(posedge aclk);
    button_low <= 1'b0;
  endtask

  task tally_and_finish;
    $display("counts: %0d compares, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`BRS_ADDR_SYSCFG, 32'h0, `BRS_RESP_OKAY);
    axi_rd(`BRS_ADDR_FLAGS, 32'(`BRS_FLAGS_POWERON), `BRS_RESP_OKAY);
    axi_rd(4'hc, 32'h0, `BRS_RESP_SLVERR);
    check(32'(reset_output_pin), 32'h0);
    $display("test reset_values done");
    axi_wr(`BRS_ADDR_SYSCFG, 32'h9, `BRS_RESP_OKAY);
    axi_rd(`BRS_ADDR_SYSCFG, 32'h9, `BRS_RESP_OKAY);
    kick(1'b0);
    repeat (3) @(posedge aclk);
    check(32'(reset_input_pin_oe), 32'h1);
    check(32'(pin_out), 32'h0);
    wait_idle;
    axi_rd(`BRS_ADDR_FLAGS, 32'(`BRS_FLAGS_SHORT), `BRS_RESP_OKAY);
    axi_rd(`BRS_ADDR_SYSCFG, 32'h1, `BRS_RESP_OKAY);
    check(32'(sense_pullup_en), 32'h1);
    $display("test soft_degeneration done");
    axi_wr(`BRS_ADDR_SYSCFG, 32'h8, `BRS_RESP_OKAY);
    kick(1'b1);
    repeat (100) @(posedge aclk);
    sense_gnd <= 1'b1;
    repeat (4) @(posedge aclk);
    check(32'(reset_input_pin_oe), 32'h0);
    check(32'(core_reset_n), 32'h0);
    sense_gnd <= 1'b0;
    wait_idle;
    $display("test sense_release done");
    axi_wr(`BRS_ADDR_SYSCFG, 32'h8, `BRS_RESP_OKAY);
    external_access_select <= 1'b1;
    kick(1'b1);
    wait_idle;
    axi_rd(`BRS_ADDR_FLAGS, 32'(`BRS_FLAGS_WDT), `BRS_RESP_OKAY);
    external_access_select <= 1'b0;
    $display("test flash_boot done");
    press(1);
    repeat (20) @(posedge aclk);
    axi_rd(`BRS_ADDR_FLAGS, 32'(`BRS_FLAGS_WDT), `BRS_RESP_OKAY);
    press(10);
    wait_idle;
    axi_rd(`BRS_ADDR_FLAGS, 32'(`BRS_FLAGS_SHORT), `BRS_RESP_OKAY);
    // Hold the button past the sense drain; long and asynchronous flags match, so look at the state
    @(posedge aclk);
    button_low <= 1'b1;
    repeat (1100) @(posedge aclk);
    axi_rd(`BRS_ADDR_STATUS, 32'h30, `BRS_RESP_OKAY);
    button_low <= 1'b0;
    wait_idle;
    axi_rd(`BRS_ADDR_FLAGS, 32'(`BRS_FLAGS_ASYNC), `BRS_RESP_OKAY);
    $display("test external_pulses done");
    end_of_init_instruction <= 1'b1;
    @(posedge aclk);
    end_of_init_instruction <= 1'b0;
    repeat (3) @(posedge aclk);
    check(32'(reset_output_pin), 32'h1);
    axi_wr(`BRS_ADDR_SYSCFG, 32'h8, `BRS_RESP_OKAY);
    axi_rd(`BRS_ADDR_SYSCFG, 32'h0, `BRS_RESP_OKAY);
    axi_wr(4'hc, 32'h0, `BRS_RESP_SLVERR);
    $display("test end_of_init done");
    tally_and_finish;
  end
endmodule // brs_sequencer_tb
